// ==== rtl/adcfmt_cfg.svh ====
`ifndef ADCFMT_CFG_SVH
`define ADCFMT_CFG_SVH

// Register byte offsets on the Wishbone slave.
`define ADCFMT_OFS_CTRL0 8'h00
`define ADCFMT_OFS_CTRL1 8'h04
`define ADCFMT_OFS_CTRL2 8'h08
`define ADCFMT_OFS_RES_HI 8'h0C
`define ADCFMT_OFS_RES_LO 8'h10
`define ADCFMT_OFS_STAT 8'h14
`define ADCFMT_OFS_CLR 8'h18
`define ADCFMT_OFS_IEN 8'h1C

// Field positions.
`define ADCFMT_ON_BIT 0
`define ADCFMT_GO_BIT 1
`define ADCFMT_CHS_LSB 2
`define ADCFMT_CHS_MSB 6
`define ADCFMT_PREF_LSB 0
`define ADCFMT_PREF_MSB 1
`define ADCFMT_NREF_BIT 2
`define ADCFMT_CS_LSB 4
`define ADCFMT_CS_MSB 6
`define ADCFMT_FM_BIT 7
`define ADCFMT_TRIG_LSB 4
`define ADCFMT_TRIG_MSB 7
`define ADCFMT_ST_DONE 0
`define ADCFMT_ST_MISS 1

// Reset values.
`define ADCFMT_CTRL_RST 8'h00
`define ADCFMT_STAT_RST 2'h0

// Sizes.
`define ADCFMT_NBITS 10
`define ADCFMT_TRIG_N 13
`define ADCFMT_TRIG_MAX 4'hD

// Timing: system clock rate and the internal RC conversion clock period.
`define ADCFMT_CLK_MHZ 200
`define ADCFMT_FRC_NS 1000
`define ADCFMT_FRC_CYC ((`ADCFMT_FRC_NS * `ADCFMT_CLK_MHZ + 999) / 1000)

`endif

// ==== rtl/adcfmt_conv_if.sv ====
interface adcfmt_conv_if;
   logic start;
   logic abort;
   adcfmt_pkg::adcfmt_clksel_t clk_sel;
   logic busy;
   logic done;
   adcfmt_pkg::adcfmt_result_t result;
   modport ctrl (output start, output abort, output clk_sel,
                 input busy, input done, input result);
   modport seq (input start, input abort, input clk_sel,
                output busy, output done, output result);
endinterface

// ==== rtl/adcfmt_pkg.sv ====
package adcfmt_pkg;
   typedef logic [9:0] adcfmt_result_t;
   typedef logic [2:0] adcfmt_clksel_t;
   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_SETTLE,
      SEQ_TRIAL
   } adcfmt_seq_e;
endpackage

// ==== rtl/adcfmt_sar.sv ====
`include "adcfmt_cfg.svh"

module adcfmt_sar (
   input wire logic clk_i,
   input wire logic rst_i,
   adcfmt_conv_if.seq cv,
   input wire logic cmp_i,
   output logic [9:0] dac_code_o,
   output logic sample_o
);
   adcfmt_pkg::adcfmt_seq_e state;
   logic [7:0] div_cnt;
   logic [3:0] bit_idx;
   logic [9:0] trial_bit;
   logic [9:0] kept_code;
   logic [7:0] tad_len;

   function automatic logic [7:0] tad_cycles(input logic [2:0] s);
      logic [7:0] n;
      n = 8'(`ADCFMT_FRC_CYC);
      case (s)
         3'h0: n = 8'h02;
         3'h1: n = 8'h08;
         3'h2: n = 8'h20;
         3'h4: n = 8'h04;
         3'h5: n = 8'h10;
         3'h6: n = 8'h40;
         default: n = 8'(`ADCFMT_FRC_CYC);
      endcase
      return n;
   endfunction

   assign tad_len = tad_cycles(cv.clk_sel) - 8'h01;
   assign trial_bit = 10'h001 << bit_idx;
   assign kept_code = cmp_i ? dac_code_o : (dac_code_o & ~trial_bit);
   assign cv.busy = (state != adcfmt_pkg::SEQ_IDLE);
   // The hold switch only reopens; nothing ever discharges the hold node.
   assign sample_o = (state == adcfmt_pkg::SEQ_IDLE);

   always_ff @(posedge clk_i) begin
      cv.done <= 1'b0;
      if (rst_i || cv.abort) begin
         state <= adcfmt_pkg::SEQ_IDLE;
         div_cnt <= 8'h00;
         bit_idx <= 4'h0;
         dac_code_o <= 10'h000;
      end else begin
         unique case (state)
            adcfmt_pkg::SEQ_IDLE: begin
               if (cv.start) begin
                  state <= adcfmt_pkg::SEQ_SETTLE;
                  div_cnt <= tad_len;
               end
            end
            adcfmt_pkg::SEQ_SETTLE: begin
               if (div_cnt == 8'h00) begin
                  state <= adcfmt_pkg::SEQ_TRIAL;
                  bit_idx <= 4'h9;
                  dac_code_o <= 10'h200;
                  div_cnt <= tad_len;
               end else begin
                  div_cnt <= div_cnt - 8'h01;
               end
            end
            adcfmt_pkg::SEQ_TRIAL: begin
               if (div_cnt != 8'h00) begin
                  div_cnt <= div_cnt - 8'h01;
               end else if (bit_idx == 4'h0) begin
                  cv.result <= kept_code;
                  cv.done <= 1'b1;
                  dac_code_o <= kept_code;
                  state <= adcfmt_pkg::SEQ_IDLE;
               end else begin
                  dac_code_o <= kept_code | (trial_bit >> 1);
                  bit_idx <= bit_idx - 4'h1;
                  div_cnt <= tad_len;
               end
            end
         endcase
      end
   end
endmodule

// ==== rtl/adcfmt_top.sv ====
// The Wishbone register port and the address map were left to the implementer.
`include "adcfmt_cfg.svh"

module adcfmt_top (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [12:0] trig_i,
   input wire logic cmp_i,
   output logic [9:0] dac_code_o,
   output logic sample_o,
   output logic converter_on_o,
   output logic [4:0] input_channel_select_o,
   output logic [2:0] conv_clk_sel_o,
   output logic neg_ref_sel_o,
   output logic [1:0] pos_ref_sel_o,
   output logic conv_busy_o,
   output logic irq_o
);
   adcfmt_conv_if cv();

   // Control state.
   logic converter_on;
   logic conv_go;
   logic [4:0] input_channel_select;
   logic result_justify_select;
   logic [2:0] conv_clk_sel;
   logic neg_ref_sel;
   logic [1:0] pos_ref_sel;
   logic [3:0] auto_trigger_source;
   logic [7:0] result_high_byte;
   logic [7:0] result_low_byte;
   logic [1:0] irq_status;
   logic [1:0] irq_enable;

   // Synchronisers for pins from outside the clock domain.
   logic cmp_meta;
   logic cmp_sync;
   logic [12:0] trig_meta;
   logic [12:0] trig_sync;
   logic [12:0] trig_prev;
   logic [12:0] trig_rise;

   always_ff @(posedge clk_i) begin
      cmp_meta <= cmp_i;
      cmp_sync <= cmp_meta;
   end

   genvar g;
   generate
      for (g = 0; g < `ADCFMT_TRIG_N; g = g + 1) begin : g_trig
         always_ff @(posedge clk_i) begin
            trig_meta[g] <= trig_i[g];
            trig_sync[g] <= trig_meta[g];
            trig_prev[g] <= trig_sync[g];
         end
         // Level-high sources are ignored; only a low-to-high step counts.
         assign trig_rise[g] = trig_sync[g] & ~trig_prev[g];
      end
   endgenerate

   // Bus decode. A write takes effect on the edge where ack is sampled.
   logic bus_req;
   logic bus_wr;
   logic wr_ctrl0;
   logic wr_ctrl1;
   logic wr_ctrl2;
   logic wr_res_hi;
   logic wr_res_lo;
   logic wr_clr;
   logic wr_ien;
   logic [7:0] wr_byte;

   assign bus_req = wb_cyc_i & wb_stb_i;
   assign bus_wr = bus_req & wb_we_i & wb_ack_o & wb_sel_i[0];
   assign wr_byte = wb_dat_i[7:0];
   assign wr_ctrl0 = bus_wr & (wb_adr_i == `ADCFMT_OFS_CTRL0);
   assign wr_ctrl1 = bus_wr & (wb_adr_i == `ADCFMT_OFS_CTRL1);
   assign wr_ctrl2 = bus_wr & (wb_adr_i == `ADCFMT_OFS_CTRL2);
   assign wr_res_hi = bus_wr & (wb_adr_i == `ADCFMT_OFS_RES_HI);
   assign wr_res_lo = bus_wr & (wb_adr_i == `ADCFMT_OFS_RES_LO);
   assign wr_clr = bus_wr & (wb_adr_i == `ADCFMT_OFS_CLR);
   assign wr_ien = bus_wr & (wb_adr_i == `ADCFMT_OFS_IEN);

   // Read mux; reserved and unmapped locations read as zero.
   logic [7:0] rd_ctrl0;
   logic [7:0] rd_ctrl1;
   logic [7:0] rd_ctrl2;
   logic [7:0] rd_byte;

   assign rd_ctrl0 = {1'b0, input_channel_select, conv_go, converter_on};
   assign rd_ctrl1 = {result_justify_select, conv_clk_sel, 1'b0,
                      neg_ref_sel, pos_ref_sel};
   assign rd_ctrl2 = {auto_trigger_source, 4'h0};
   assign rd_byte =
      (wb_adr_i == `ADCFMT_OFS_CTRL0) ? rd_ctrl0 :
      (wb_adr_i == `ADCFMT_OFS_CTRL1) ? rd_ctrl1 :
      (wb_adr_i == `ADCFMT_OFS_CTRL2) ? rd_ctrl2 :
      (wb_adr_i == `ADCFMT_OFS_RES_HI) ? result_high_byte :
      (wb_adr_i == `ADCFMT_OFS_RES_LO) ? result_low_byte :
      (wb_adr_i == `ADCFMT_OFS_STAT) ? {6'h00, irq_status} :
      (wb_adr_i == `ADCFMT_OFS_IEN) ? {6'h00, irq_enable} : 8'h00;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= bus_req & ~wb_ack_o;
         if (bus_req & ~wb_ack_o) begin
            wb_dat_o <= {24'h000000, rd_byte};
         end
      end
   end

   // Conversion start, abort and completion.
   logic on_next;
   logic sw_go_set;
   logic sw_go_clr;
   logic conv_idle;
   logic trig_valid;
   logic [3:0] trig_idx;
   logic trig_hit;
   logic conv_start;
   logic conv_abort;
   logic next_go;
   logic missed_trig;

   // The enable written in the same access counts, so one write can
   // turn the converter on and start it.
   assign on_next = wr_ctrl0 ? wr_byte[`ADCFMT_ON_BIT] : converter_on;
   assign sw_go_set = wr_ctrl0 & wr_byte[`ADCFMT_GO_BIT];
   assign sw_go_clr = wr_ctrl0 & ~wr_byte[`ADCFMT_GO_BIT];
   // A conversion that ends this cycle frees the converter for a new start.
   assign conv_idle = ~conv_go | cv.done;
   assign trig_valid = (auto_trigger_source != 4'h0) &&
                       (auto_trigger_source <= `ADCFMT_TRIG_MAX);
   assign trig_idx = auto_trigger_source - 4'h1;
   assign trig_hit = trig_valid & trig_rise[trig_idx];
   assign conv_start = on_next & conv_idle & (sw_go_set | trig_hit);
   // Switching the converter off or writing go low stops a running cycle.
   assign conv_abort = conv_go & ~cv.done & (~on_next | sw_go_clr);
   assign next_go = conv_start ? 1'b1 :
                    (cv.done | conv_abort) ? 1'b0 : conv_go;
   // A trigger edge that lands while busy is dropped and reported.
   assign missed_trig = trig_hit & on_next & ~conv_idle;

   assign cv.start = conv_start;
   assign cv.abort = conv_abort;
   assign cv.clk_sel = conv_clk_sel;

   adcfmt_sar u_sar (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cv(cv.seq),
      .cmp_i(cmp_sync),
      .dac_code_o(dac_code_o),
      .sample_o(sample_o)
   );

   // Control registers.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         converter_on <= 1'(`ADCFMT_CTRL_RST >> `ADCFMT_ON_BIT);
         conv_go <= 1'b0;
         input_channel_select <= 5'h00;
         result_justify_select <= 1'b0;
         conv_clk_sel <= 3'h0;
         neg_ref_sel <= 1'b0;
         pos_ref_sel <= 2'h0;
         auto_trigger_source <= 4'h0;
      end else begin
         conv_go <= next_go;
         if (wr_ctrl0) begin
            converter_on <= wr_byte[`ADCFMT_ON_BIT];
            input_channel_select <= wr_byte[`ADCFMT_CHS_MSB:`ADCFMT_CHS_LSB];
         end
         if (wr_ctrl1) begin
            result_justify_select <= wr_byte[`ADCFMT_FM_BIT];
            conv_clk_sel <= wr_byte[`ADCFMT_CS_MSB:`ADCFMT_CS_LSB];
            neg_ref_sel <= wr_byte[`ADCFMT_NREF_BIT];
            pos_ref_sel <= wr_byte[`ADCFMT_PREF_MSB:`ADCFMT_PREF_LSB];
         end
         if (wr_ctrl2) begin
            auto_trigger_source <= wr_byte[`ADCFMT_TRIG_MSB:`ADCFMT_TRIG_LSB];
         end
      end
   end

   // Result formatting at load time.
   logic [7:0] fmt_high;
   logic [7:0] fmt_low;

   assign fmt_high = result_justify_select ?
      {6'h00, cv.result[9:8]} :
      cv.result[9:2];
   assign fmt_low = result_justify_select ?
      cv.result[7:0] :
      {cv.result[1:0], 6'h00};

   // The result bytes have no reset so their contents survive any reset;
   // a load from the converter wins over a software write in the same cycle.
   always_ff @(posedge clk_i) begin
      if (cv.done) begin
         result_high_byte <= fmt_high;
         result_low_byte <= fmt_low;
      end else begin
         if (wr_res_hi) begin
            result_high_byte <= wr_byte;
         end
         if (wr_res_lo) begin
            result_low_byte <= wr_byte;
         end
      end
   end

   // Interrupt status: set wins over a clear in the same cycle.
   logic [1:0] irq_events;
   logic [1:0] irq_clear;

   assign irq_events = {missed_trig, cv.done};
   assign irq_clear = wr_clr ? wr_byte[1:0] : 2'h0;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_status <= `ADCFMT_STAT_RST;
         irq_enable <= 2'h0;
      end else begin
         irq_status <= (irq_status & ~irq_clear) | irq_events;
         if (wr_ien) begin
            irq_enable <= wr_byte[1:0];
         end
      end
   end

   assign irq_o = |(irq_status & irq_enable);
   assign converter_on_o = converter_on;
   assign input_channel_select_o = input_channel_select;
   assign conv_clk_sel_o = conv_clk_sel;
   assign neg_ref_sel_o = neg_ref_sel;
   assign pos_ref_sel_o = pos_ref_sel;
   assign conv_busy_o = conv_go;
endmodule

// ==== test/adcfmt_checker.sv ====
`include "adcfmt_cfg.svh"

module adcfmt_checker (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [9:0] dac_code_o,
   input wire logic sample_o,
   input wire logic converter_on_o,
   input wire logic [2:0] conv_clk_sel_o,
   input wire logic conv_busy_o,
   input wire logic irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [7:0] busy_cnt;
   wire ctrl_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0]
      & (wb_adr_i == `ADCFMT_OFS_CTRL0);
   // Counts busy cycles so the conversion length is checked exactly.
   always_ff @(posedge clk_i) begin
      if (rst_i || !conv_busy_o) busy_cnt <= 8'h00;
      else busy_cnt <= busy_cnt + 8'h01;
   end
   go_start_a: assert property (ctrl_wr && wb_dat_i[1:0] == 2'h3
      && !conv_busy_o |=> conv_busy_o) else $error("go did not start");
   go_off_a: assert property (ctrl_wr && wb_dat_i[1:0] == 2'h2
      |=> !conv_busy_o) else $error("go started while off");
   busy_on_a: assert property ($rose(conv_busy_o) |-> converter_on_o)
      else $error("conversion without enable");
   // Eight-cycle conversion clock: one settle and ten bit periods plus one.
   // A drop right after a control write is an abort, not a finished run.
   conv_len_a: assert property ($fell(conv_busy_o)
      && !$past(ctrl_wr) && conv_clk_sel_o == 3'h1 |-> busy_cnt == 8'h59)
      else $error("conversion length wrong");
   // On a finished run the hold switch reopens one cycle before the go bit drops.
   sample_hold_a: assert property (conv_busy_o ?
      !(sample_o && $past(sample_o)) : sample_o)
      else $error("sample phase wrong");
   dac_hold_a: assert property ($fell(conv_busy_o)
      |=> $stable(dac_code_o)) else $error("final code not held");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   ack_next_a: assert property ($rose(wb_stb_i) && wb_cyc_i |=> wb_ack_o)
      else $error("ack late");
   reset_idle_a: assert property ($fell(rst_i) |-> !conv_busy_o && !irq_o
      && !converter_on_o && wb_dat_o[31:8] == 24'h000000)
      else $error("not idle after reset");
endmodule

bind adcfmt_top adcfmt_checker i_chk (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dac_code_o(dac_code_o),
   .sample_o(sample_o), .converter_on_o(converter_on_o),
   .conv_clk_sel_o(conv_clk_sel_o), .conv_busy_o(conv_busy_o),
   .irq_o(irq_o));

// ==== test/tb_top.sv ====
`include "adcfmt_cfg.svh"

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic cmp_i = 1'b0, fm = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0, rng = 32'h49, wb_dat_o;
   logic [12:0] trig_i = 13'h0;
   logic [9:0] vin = 10'h0, dac_code_o;
   logic [63:0] note;
   logic [63:0] q[$];
   logic wb_ack_o, conv_busy_o, irq_o, neg_o;
   logic [4:0] chs_o;
   logic [1:0] pos_o;
   int n_mismatch = 0, check_count = 0, k;
   always #2.5 clk_i = ~clk_i;
   adcfmt_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
      .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .trig_i(trig_i), .cmp_i(cmp_i), .dac_code_o(dac_code_o),
      .sample_o(), .converter_on_o(), .input_channel_select_o(chs_o),
      .conv_clk_sel_o(), .neg_ref_sel_o(neg_o), .pos_ref_sel_o(pos_o),
      .conv_busy_o(conv_busy_o), .irq_o(irq_o));
   // Comparator registered on each clock edge; the design's two-stage synchroniser adds two more cycles of lag.
   always @(posedge clk_i) cmp_i <= ((dac_code_o <= vin) === 1'b1);
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic fail();
      n_mismatch++;
      final_report();
   endtask
   // Every access leaves a note; writes carry an empty mask.
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                      input logic [31:0] m);
      int i;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= {24'h0, d};
      q.push_back({m, 24'h0, d});
      for (i = 0; i < 20; i++) begin
         @(posedge clk_i);
         if (wb_ack_o === 1'b1) break;
      end
      cyc <= 1'b0;
      stb <= 1'b0;
      if (i == 20) fail();
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      acc(1'b1, a, d, 32'h0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      acc(1'b0, a, e, 32'hFFFFFFFF);
   endtask
   task automatic cv();
      int i;
      i = 0;
      while (conv_busy_o !== 1'b1) begin
         @(posedge clk_i);
         if (++i > 12) fail();
      end
      i = 0;
      while (conv_busy_o !== 1'b0) begin
         @(posedge clk_i);
         if (++i > 200) fail();
      end
   endtask
   task automatic chk(input logic e);
      check_count++;
      if (irq_o !== e) begin
         n_mismatch++;
         $display("ERROR irq_o exp %b got %b", e, irq_o);
      end
   endtask
   task automatic ochk(input string s, input logic [7:0] e,
                       input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %s exp %h got %h", s, e, g);
      end
   endtask
   always @(posedge clk_i) begin
      if (wb_ack_o === 1'b1 && q.size() > 0) begin
         note = q.pop_front();
         if (note[63:32] != 32'h0) begin
            check_count++;
            if (wb_dat_o !== note[31:0]) begin
               n_mismatch++;
               $display("ERROR reg %h exp %h got %h", adr, note[31:0],
                        wb_dat_o);
            end
         end
      end
   end
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(`ADCFMT_OFS_CTRL0, 8'h00);
      rd(`ADCFMT_OFS_STAT, 8'h00);
      rd(8'h20, 8'h00);
      wr(`ADCFMT_OFS_IEN, 8'h01);
      for (k = 0; k < 4; k++) begin
         rng = xs(rng);
         vin <= rng[9:0];
         fm = k[0];
         wr(`ADCFMT_OFS_CTRL1, {fm, 4'h2, rng[17:15]});
         wr(`ADCFMT_OFS_CTRL0, {1'b0, rng[14:10], 2'h1});
         repeat (20) @(posedge clk_i);
         wr(`ADCFMT_OFS_CTRL0, {1'b0, rng[14:10], 2'h3});
         cv();
         rd(`ADCFMT_OFS_CTRL0, {1'b0, rng[14:10], 2'h1});
         rd(`ADCFMT_OFS_CTRL1, {fm, 4'h2, rng[17:15]});
         ochk("channel", {3'h0, rng[14:10]}, {3'h0, chs_o});
         ochk("refs", {5'h0, rng[17:15]}, {5'h0, neg_o, pos_o});
         rd(`ADCFMT_OFS_RES_HI, fm ? {6'h0, vin[9:8]} : vin[9:2]);
         rd(`ADCFMT_OFS_RES_LO, fm ? vin[7:0] : {vin[1:0], 6'h0});
         rd(`ADCFMT_OFS_STAT, 8'h01);
         chk(1'b1);
         wr(`ADCFMT_OFS_CLR, 8'h01);
         rd(`ADCFMT_OFS_STAT, 8'h00);
         chk(1'b0);
      end
      wr(`ADCFMT_OFS_RES_HI, 8'hA5);
      wr(`ADCFMT_OFS_RES_LO, 8'h5A);
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(`ADCFMT_OFS_RES_HI, 8'hA5);
      rd(`ADCFMT_OFS_RES_LO, 8'h5A);
      rd(`ADCFMT_OFS_CTRL1, 8'h00);
      wr(`ADCFMT_OFS_CTRL0, 8'h02);
      repeat (12) @(posedge clk_i);
      rd(`ADCFMT_OFS_CTRL0, 8'h00);
      wr(`ADCFMT_OFS_CTRL1, 8'h10);
      wr(`ADCFMT_OFS_CTRL0, 8'h01);
      // Other sources toggle first: only the selected edge may start.
      for (k = 1; k <= 13; k++) begin
         wr(`ADCFMT_OFS_CTRL2, {k[3:0], 4'h0});
         trig_i <= ~(13'h1 << (k - 1));
         repeat (8) @(posedge clk_i);
         rd(`ADCFMT_OFS_CTRL0, 8'h01);
         trig_i <= 13'h1FFF;
         cv();
         repeat (12) @(posedge clk_i);
         rd(`ADCFMT_OFS_CTRL0, 8'h01);
         trig_i <= 13'h0;
         repeat (4) @(posedge clk_i);
      end
      // Reserved trigger code 14 must never start a conversion.
      wr(`ADCFMT_OFS_CTRL2, 8'hE0);
      trig_i <= 13'h1FFF;
      repeat (8) @(posedge clk_i);
      rd(`ADCFMT_OFS_CTRL0, 8'h01);
      trig_i <= 13'h0;
      // A second edge while busy is dropped and flagged.
      wr(`ADCFMT_OFS_CTRL2, 8'h10);
      trig_i <= 13'h1FFF;
      repeat (8) @(posedge clk_i);
      trig_i <= 13'h0;
      repeat (4) @(posedge clk_i);
      trig_i <= 13'h1FFF;
      cv();
      rd(`ADCFMT_OFS_STAT, 8'h03);
      chk(1'b0);
      wr(`ADCFMT_OFS_IEN, 8'h01);
      @(posedge clk_i);
      chk(1'b1);
      wr(`ADCFMT_OFS_CLR, 8'h01);
      @(posedge clk_i);
      chk(1'b0);
      final_report();
   end
endmodule
